//--- async_serial_pkg.sv
package async_serial_pkg;

    // ==========================================
    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // ==========================================
    // Register offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_BAUD = 4'h1;
    localparam logic [3:0] OFS_TXB = 4'h2;
    localparam logic [3:0] OFS_RXB = 4'h3;
    localparam logic [3:0] OFS_STAT = 4'h4;

    // ==========================================
    // Control register layout, low bits of the word
    typedef struct packed {
        logic [3:0] mode;
        logic tx_buffer_empty_irq_enable;
        logic tx_shifter_empty_enable;
        logic tx_polarity;
        logic baud_speed_select;
        logic rx_enable;
        logic tx_enable;
        logic module_enable;
    } ctrl_s;
    localparam int CTRL_W = 11;
    localparam logic [10:0] CTRL_RESET = 11'h000;
    localparam logic [15:0] BAUD_RESET = 16'h0000;

    // Status register bit positions
    localparam int ST_TXBE = 0;
    localparam int ST_TXMT = 1;
    localparam int ST_RXDATA = 2;
    localparam int ST_FERR = 3;
    localparam int ST_PERR = 4;
    localparam int ST_SUMERR = 5;

    // ==========================================
    // Mode codes
    localparam logic [3:0] MODE_8BIT = 4'h0;
    localparam logic [3:0] MODE_7BIT = 4'h1;
    localparam logic [3:0] MODE_ODD = 4'h2;
    localparam logic [3:0] MODE_EVEN = 4'h3;

    // ==========================================
    // Bit timing in divider ticks
    localparam logic [3:0] LAST_TICK_NORMAL = 4'hF;
    localparam logic [3:0] LAST_TICK_HIGH = 4'h3;
    localparam logic [3:0] EARLY_1 = 4'h1;
    localparam logic [3:0] EARLY_2 = 4'h2;
    localparam logic [3:0] MID_1 = 4'h7;
    localparam logic [3:0] MID_2 = 4'h8;
    localparam logic [3:0] MID_3 = 4'h9;
    localparam logic [3:0] MID_HIGH = 4'h2;

    // ==========================================
    // Received character with its error marks
    typedef struct packed {
        logic perr;
        logic ferr;
        logic [7:0] data;
    } rx_word_s;
    localparam int RX_WORD_W = 10;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_e;

endpackage

//--- rx_fifo_mem.sv
// Small receive FIFO; the head entry always sits in a register
module rx_fifo_mem #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 2
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clear,
    input wire logic i_push,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic i_pop,
    output logic [WIDTH-1:0] o_head,
    output logic o_empty,
    output logic o_full
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    logic do_push;
    logic do_pop;
    logic [PW-1:0] rd_d;

    // Push is dropped when full, so an overflowing character is lost
    assign o_full = (cnt_q == (PW+1)'(DEPTH));
    assign o_empty = (cnt_q == '0);
    assign do_push = i_push && !o_full;
    assign do_pop = i_pop && !o_empty;
    assign rd_d = do_pop ? ((rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;

    // Pointers and count
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (i_clear) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            rd_q <= rd_d;
            cnt_q <= cnt_q + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end
    end

    // Storage needs no reset
    always_ff @(posedge i_clk) begin
        if (do_push) begin
            mem_q[wr_q] <= i_wdata;
        end
    end

    // Head register forwards a word being written into the next head slot
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_head <= '0;
        end else if (do_push && wr_q == rd_d) begin
            o_head <= i_wdata;
        end else begin
            o_head <= mem_q[rd_d];
        end
    end
endmodule // rx_fifo_mem

//--- async_serial_transmitter.sv
// What this block does
// - start, 7/8 data, optional parity, stop
// - least significant bit goes first
// - bit period from 16-bit baud divider
// - independent paths, shared format and baud
// - transmit needs enable, mode 0-3, master
// - drive pin while busy, else direction input
// - write starts sending; empty shifter loads
// - queued byte loads at stop start
// - back-to-back characters with no gap
// - polarity resets zero; one inverts all
// - polarity change reaches pin at once
// - buffer-empty flag read-only, enable gated
// - shifter-empty flag tracks load and finish
// - shifter-empty feeds summary error output
// - mode 0001 sends seven low bits
// - odd/even parity ninth bit by mode
// - receiver samples at 16x or 4x
// - finished character enters two-entry FIFO
// - received data only via read register
// - normal speed majority of 7,8,9
// - both early samples high means glitch
// - high speed takes one sample per bit
module async_serial_transmitter #(
    parameter int RX_DEPTH = 2
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [async_serial_pkg::ADDR_W-1:0] i_addr,
    input wire logic [async_serial_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [async_serial_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_rx,
    input wire logic i_pin_direction,
    output logic o_tx,
    output logic o_tx_oe_n,
    output logic o_rx_data_flag,
    output logic o_summary_error_irq
);
    // ==========================================
    // Registers
    async_serial_pkg::ctrl_s ctrl_q;
    logic [15:0] baud_divisor_q;
    logic mode_ok;
    logic par_mode;
    logic seven;
    logic [3:0] last_tick;
    logic wr_ctrl;
    logic wr_baud;
    logic wr_txb;
    logic rd_rxb;

    assign wr_ctrl = i_wr && i_addr == async_serial_pkg::OFS_CTRL;
    assign wr_baud = i_wr && i_addr == async_serial_pkg::OFS_BAUD;
    assign wr_txb = i_wr && i_addr == async_serial_pkg::OFS_TXB;
    assign rd_rxb = i_rd && i_addr == async_serial_pkg::OFS_RXB;
    assign mode_ok = ctrl_q.mode[3:2] == 2'b00;
    assign par_mode = ctrl_q.mode == async_serial_pkg::MODE_ODD || ctrl_q.mode == async_serial_pkg::MODE_EVEN;
    assign seven = ctrl_q.mode == async_serial_pkg::MODE_7BIT;
    // One format and one bit length serve both directions
    assign last_tick = ctrl_q.baud_speed_select ? async_serial_pkg::LAST_TICK_HIGH
                                                : async_serial_pkg::LAST_TICK_NORMAL;

    // Control and divisor writes
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= async_serial_pkg::CTRL_RESET;
            baud_divisor_q <= async_serial_pkg::BAUD_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= async_serial_pkg::ctrl_s'(i_wdata[async_serial_pkg::CTRL_W-1:0]);
            end
            if (wr_baud) begin
                baud_divisor_q <= i_wdata;
            end
        end
    end

    // ==========================================
    // Transmitter
    async_serial_pkg::tx_state_e tx_state_q;
    logic tx_run;
    logic [15:0] tx_pre_q;
    logic [3:0] tx_sub_q;
    logic tx_tick;
    logic tx_bit_end;
    logic [7:0] tx_shift_register_q;
    logic [7:0] tx_buffer_q;
    logic tx_buf_full_q;
    logic tx_pend_q;
    logic tx_par_q;
    logic [2:0] tx_bits_q;
    logic [2:0] tx_last_bit;
    logic [7:0] tx_load;
    logic tx_line;
    logic tx_idle;
    logic tx_shifter_empty_flag;
    logic tx_buffer_empty_flag;

    assign tx_run = ctrl_q.module_enable && ctrl_q.tx_enable && mode_ok;
    assign tx_tick = tx_pre_q == baud_divisor_q;
    assign tx_bit_end = tx_tick && tx_sub_q == last_tick;
    assign tx_last_bit = seven ? 3'd6 : 3'd7;
    assign tx_idle = tx_state_q == async_serial_pkg::TX_IDLE;
    assign tx_shifter_empty_flag = tx_idle;
    assign tx_buffer_empty_flag = tx_run && !tx_buf_full_q;
    // Top bit is cleared in seven-bit mode so parity and shifting ignore it
    assign tx_load = tx_buf_full_q ? {tx_buffer_q[7] & ~seven, tx_buffer_q[6:0]}
                                   : {i_wdata[7] & ~seven, i_wdata[6:0]};

    // Bit timing restarts whenever a character leaves idle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_pre_q <= '0;
            tx_sub_q <= '0;
        end else if (tx_idle) begin
            tx_pre_q <= '0;
            tx_sub_q <= '0;
        end else if (tx_tick) begin
            tx_pre_q <= '0;
            tx_sub_q <= (tx_sub_q == last_tick) ? 4'h0 : tx_sub_q + 4'h1;
        end else begin
            tx_pre_q <= tx_pre_q + 16'h0001;
        end
    end

    // Frame sequencer, transmit buffer and shifter handoff
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_state_q <= async_serial_pkg::TX_IDLE;
            tx_shift_register_q <= '0;
            tx_buffer_q <= '0;
            tx_buf_full_q <= 1'b0;
            tx_pend_q <= 1'b0;
            tx_par_q <= 1'b0;
            tx_bits_q <= '0;
        end else if (!tx_run) begin
            tx_state_q <= async_serial_pkg::TX_IDLE;
            tx_buf_full_q <= 1'b0;
            tx_pend_q <= 1'b0;
        end else begin
            if (wr_txb && !tx_idle && !tx_buf_full_q) begin
                tx_buffer_q <= i_wdata[7:0];
                tx_buf_full_q <= 1'b1;
            end
            case (tx_state_q)
                async_serial_pkg::TX_IDLE: begin
                    if (wr_txb) begin
                        tx_shift_register_q <= tx_load;
                        tx_par_q <= ^tx_load ^ (ctrl_q.mode == async_serial_pkg::MODE_ODD);
                        tx_state_q <= async_serial_pkg::TX_START;
                    end
                end
                async_serial_pkg::TX_START: begin
                    if (tx_bit_end) begin
                        tx_bits_q <= '0;
                        tx_state_q <= async_serial_pkg::TX_DATA;
                    end
                end
                async_serial_pkg::TX_DATA: begin
                    if (tx_bit_end) begin
                        tx_shift_register_q <= {1'b0, tx_shift_register_q[7:1]};
                        tx_bits_q <= tx_bits_q + 3'd1;
                        if (tx_bits_q == tx_last_bit) begin
                            tx_state_q <= par_mode ? async_serial_pkg::TX_PARITY : async_serial_pkg::TX_STOP;
                        end
                        if (tx_bits_q == tx_last_bit && !par_mode && tx_buf_full_q) begin
                            tx_shift_register_q <= tx_load;
                            tx_par_q <= ^tx_load ^ (ctrl_q.mode == async_serial_pkg::MODE_ODD);
                            tx_buf_full_q <= 1'b0;
                            tx_pend_q <= 1'b1;
                        end
                    end
                end
                async_serial_pkg::TX_PARITY: begin
                    if (tx_bit_end) begin
                        tx_state_q <= async_serial_pkg::TX_STOP;
                        if (tx_buf_full_q) begin
                            tx_shift_register_q <= tx_load;
                            tx_par_q <= ^tx_load ^ (ctrl_q.mode == async_serial_pkg::MODE_ODD);
                            tx_buf_full_q <= 1'b0;
                            tx_pend_q <= 1'b1;
                        end
                    end
                end
                async_serial_pkg::TX_STOP: begin
                    // A byte written after the stop began is taken at its end, unless one was already loaded at stop start
                    if (tx_bit_end) begin
                        tx_pend_q <= 1'b0;
                        if (tx_pend_q) begin
                            tx_state_q <= async_serial_pkg::TX_START;
                        end else if (tx_buf_full_q || wr_txb) begin
                            tx_shift_register_q <= tx_load;
                            tx_par_q <= ^tx_load ^ (ctrl_q.mode == async_serial_pkg::MODE_ODD);
                            tx_buf_full_q <= 1'b0;
                            tx_state_q <= async_serial_pkg::TX_START;
                        end else begin
                            tx_state_q <= async_serial_pkg::TX_IDLE;
                        end
                    end
                end
                default: tx_state_q <= async_serial_pkg::TX_IDLE;
            endcase
        end
    end

    // Line level before polarity; mark between characters
    always_comb begin
        case (tx_state_q)
            async_serial_pkg::TX_START: tx_line = 1'b0;
            async_serial_pkg::TX_DATA: tx_line = tx_shift_register_q[0];
            async_serial_pkg::TX_PARITY: tx_line = tx_par_q;
            default: tx_line = 1'b1;
        endcase
    end

    // Pin drive; polarity is applied outside all enables so it acts at once
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_tx <= 1'b1;
            o_tx_oe_n <= 1'b1;
        end else begin
            o_tx <= tx_line ^ ctrl_q.tx_polarity;
            o_tx_oe_n <= (ctrl_q.tx_enable && !tx_idle) ? 1'b0 : i_pin_direction;
        end
    end

    // ==========================================
    // Receiver front end
    async_serial_pkg::rx_state_e rx_state_q;
    logic rx_s1_q;
    logic rx_s2_q;
    logic rx_s3_q;
    logic rx_run;
    logic [15:0] rx_pre_q;
    logic [3:0] rx_cnt_q;
    logic [3:0] rx_cnt_n;
    logic rx_tick;
    logic [1:0] rx_smp_q;
    logic rx_early_low_q;
    logic rx_bit;
    logic rx_dec;
    logic [7:0] rx_shift_register_q;
    logic [2:0] rx_bits_q;
    logic rx_perr_q;
    async_serial_pkg::rx_word_s rx_push_word;
    logic rx_push;
    async_serial_pkg::rx_word_s rx_head;
    logic rx_empty;
    logic rx_full;

    assign rx_run = ctrl_q.module_enable && ctrl_q.rx_enable && mode_ok;
    assign rx_tick = rx_pre_q == baud_divisor_q;
    assign rx_cnt_n = (rx_cnt_q == last_tick) ? 4'h0 : rx_cnt_q + 4'h1;
    // Majority of three in normal speed, single mid sample in high speed
    assign rx_bit = ctrl_q.baud_speed_select ? rx_s2_q
                  : ((rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[0] & rx_s2_q) | (rx_smp_q[1] & rx_s2_q));
    assign rx_dec = rx_tick && rx_cnt_n == (ctrl_q.baud_speed_select ? async_serial_pkg::MID_HIGH
                                                                      : async_serial_pkg::MID_3);
    assign rx_push = rx_state_q == async_serial_pkg::RX_STOP && rx_dec;
    assign rx_push_word = '{perr: rx_perr_q, ferr: !rx_bit,
                            data: seven ? {1'b0, rx_shift_register_q[7:1]} : rx_shift_register_q};

    // Pin synchroniser; only the second and third stages feed logic
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
        end else begin
            rx_s1_q <= i_rx;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
        end
    end

    // Divider restarts on the falling edge so bit centres line up
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_pre_q <= '0;
            rx_cnt_q <= '0;
            rx_smp_q <= '0;
        end else if (rx_state_q == async_serial_pkg::RX_IDLE) begin
            rx_pre_q <= '0;
            rx_cnt_q <= '0;
        end else if (rx_tick) begin
            rx_pre_q <= '0;
            rx_cnt_q <= rx_cnt_n;
            if (rx_cnt_n == async_serial_pkg::MID_1 || rx_cnt_n == async_serial_pkg::MID_2) begin
                rx_smp_q <= {rx_smp_q[0], rx_s2_q};
            end
        end else begin
            rx_pre_q <= rx_pre_q + 16'h0001;
        end
    end

    // Character recovery sequencer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_state_q <= async_serial_pkg::RX_IDLE;
            rx_early_low_q <= 1'b0;
            rx_shift_register_q <= '0;
            rx_bits_q <= '0;
            rx_perr_q <= 1'b0;
        end else if (!rx_run) begin
            rx_state_q <= async_serial_pkg::RX_IDLE;
        end else begin
            case (rx_state_q)
                async_serial_pkg::RX_IDLE: begin
                    if (rx_s3_q && !rx_s2_q) begin
                        rx_state_q <= async_serial_pkg::RX_START;
                        rx_early_low_q <= 1'b0;
                    end
                end
                async_serial_pkg::RX_START: begin
                    if (rx_tick && !ctrl_q.baud_speed_select && rx_cnt_n == async_serial_pkg::EARLY_1) begin
                        rx_early_low_q <= !rx_s2_q;
                    end
                    if (rx_tick && !ctrl_q.baud_speed_select && rx_cnt_n == async_serial_pkg::EARLY_2
                            && !rx_early_low_q && rx_s2_q) begin
                        rx_state_q <= async_serial_pkg::RX_IDLE;
                    end else if (rx_dec) begin
                        rx_bits_q <= '0;
                        rx_state_q <= rx_bit ? async_serial_pkg::RX_IDLE : async_serial_pkg::RX_DATA;
                    end
                end
                async_serial_pkg::RX_DATA: begin
                    if (rx_dec) begin
                        rx_shift_register_q <= {rx_bit, rx_shift_register_q[7:1]};
                        rx_bits_q <= rx_bits_q + 3'd1;
                        rx_perr_q <= 1'b0;
                        if (rx_bits_q == (seven ? 3'd6 : 3'd7)) begin
                            rx_state_q <= par_mode ? async_serial_pkg::RX_PARITY : async_serial_pkg::RX_STOP;
                        end
                    end
                end
                async_serial_pkg::RX_PARITY: begin
                    if (rx_dec) begin
                        rx_perr_q <= rx_bit != (^rx_shift_register_q ^ (ctrl_q.mode == async_serial_pkg::MODE_ODD));
                        rx_state_q <= async_serial_pkg::RX_STOP;
                    end
                end
                async_serial_pkg::RX_STOP: begin
                    // Return at mid stop so the next start edge is not missed
                    if (rx_dec) begin
                        rx_state_q <= async_serial_pkg::RX_IDLE;
                    end
                end
                default: rx_state_q <= async_serial_pkg::RX_IDLE;
            endcase
        end
    end

    // Two-entry receive FIFO, cleared while the module is off
    rx_fifo_mem #(
        .WIDTH(async_serial_pkg::RX_WORD_W),
        .DEPTH(RX_DEPTH)
    ) u_rx_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clear(!ctrl_q.module_enable),
        .i_push(rx_push),
        .i_wdata(rx_push_word),
        .i_pop(rd_rxb),
        .o_head(rx_head),
        .o_empty(rx_empty),
        .o_full(rx_full)
    );

    // ==========================================
    // Read port and flag outputs
    logic [15:0] stat_word;
    logic [15:0] rd_mux;
    logic sum_err;

    assign sum_err = (tx_shifter_empty_flag && ctrl_q.tx_shifter_empty_enable);
    assign stat_word = {10'h000, sum_err, rx_head.perr & ~rx_empty, rx_head.ferr & ~rx_empty,
                        ~rx_empty, tx_shifter_empty_flag, tx_buffer_empty_flag};
    // Shifters and FIFO entries have no address of their own
    always_comb begin
        case (i_addr)
            async_serial_pkg::OFS_CTRL: rd_mux = {5'h00, ctrl_q};
            async_serial_pkg::OFS_BAUD: rd_mux = baud_divisor_q;
            async_serial_pkg::OFS_RXB: rd_mux = rx_empty ? 16'h0000 : {8'h00, rx_head.data};
            async_serial_pkg::OFS_STAT: rd_mux = stat_word;
            default: rd_mux = 16'h0000;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= '0;
            o_rx_data_flag <= 1'b0;
            o_summary_error_irq <= 1'b0;
        end else begin
            o_rdata <= i_rd ? rd_mux : 16'h0000;
            o_rx_data_flag <= !rx_empty;
            o_summary_error_irq <= sum_err;
        end
    end

    logic unused_full;
    assign unused_full = rx_full;
endmodule // async_serial_transmitter

//--- async_serial_properties.sv
// ==========================================
// Port checks for the serial block
module async_serial_properties #(parameter int RX_DEPTH = 2) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic i_rx,
    input wire logic i_pin_direction,
    input wire logic o_tx,
    input wire logic o_tx_oe_n,
    input wire logic o_rx_data_flag,
    input wire logic o_summary_error_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Summary enable as written; the request lags it
    logic en_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) en_q <= 1'b0;
        else if (i_wr && i_addr == async_serial_pkg::OFS_CTRL) en_q <= i_wdata[5];
    end
    // ==========================================
    // Assertions
    chk_rdata_pulse: assert property (!$past(i_rd) |-> o_rdata == '0)
        else $error("read data outside answer cycle");
    chk_unmapped_zero: assert property (i_rd && i_addr > 4'h4 |=> o_rdata == '0)
        else $error("unmapped read not zero");
    chk_start_drive: assert property ($fell(o_tx_oe_n) && $past(i_pin_direction) |-> $changed(o_tx))
        else $error("drive began without start bit");
    chk_dir_handback: assert property (o_tx_oe_n |-> $past(i_pin_direction))
        else $error("pin released against direction");
    chk_bit_hold: assert property ($fell(o_tx_oe_n) && $past(i_pin_direction) |=> $stable(o_tx)[*3])
        else $error("start bit too short");
    chk_irq_masked: assert property (!en_q && !$past(en_q) |-> !o_summary_error_irq)
        else $error("summary request while masked");
    chk_irq_busy: assert property (i_pin_direction && !o_tx_oe_n ##1 !o_tx_oe_n |-> !$past(o_summary_error_irq))
        else $error("shifter empty while sending");
    chk_pol_now: assert property (i_wr && i_addr == async_serial_pkg::OFS_CTRL && !i_wdata[0] |->
        ##3 o_tx == !$past(i_wdata[4], 3)) else $error("idle level not set by polarity");
    cover property ($fell(o_tx_oe_n));
    cover property ($rose(o_rx_data_flag));
    cover property ($rose(o_summary_error_irq));
endmodule // async_serial_properties

bind async_serial_transmitter async_serial_properties #(.RX_DEPTH(RX_DEPTH)) async_serial_properties_i (.*);

//--- serial_station.sv
// ==========================================
// Remote station driving the receive pin
module serial_station #(parameter int BIT = 16) (
    input wire logic i_clk,
    output logic o_line
);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_line = 1'b1; // Rests at mark
    // One frame; a low stop bit only when asked, to provoke a framing error
    task automatic send(input logic [7:0] d, input logic bad_stop);
        logic [9:0] f;
        f = {~bad_stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_line <= f[i];
            repeat (BIT) @(posedge i_clk);
        end
        o_line <= 1'b1;
        @(posedge i_clk);
    endtask
endmodule // serial_station

//--- testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rst, i_wr, i_rd, i_rx, i_pin_direction, o_tx, o_tx_oe_n, o_rx_data_flag, o_summary_error_irq;
    logic [3:0] i_addr;
    logic [15:0] i_wdata, o_rdata, rv;
    logic [10:0] fr;
    int fails, cmp_count;
    `define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
        $display("MISMATCH %s expected %h seen %h", nm, e, s); end end
    async_serial_transmitter async_serial_transmitter_i (.*);
    serial_station serial_station_i (.i_clk(i_clk), .o_line(i_rx));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // ==========================================
    // One strobe cycle; read data taken at the next edge
    task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
        i_addr <= a;
        i_wdata <= d;
        {i_wr, i_rd} <= {w, !w};
        @(posedge i_clk);
        {i_wr, i_rd} <= 2'b00;
        @(posedge i_clk);
        rv = o_rdata;
    endtask
    task automatic rdc(input string nm, input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        `CHK(nm, e, rv & m)
    endtask
    // Samples each bit mid-way; a late start fails the start check
    task automatic cap(input int bt, input int nb, input int lim);
        int k;
        k = 0;
        fr = '1;
        while (o_tx !== 1'b0 && k < lim) begin
            @(posedge i_clk);
            k++;
        end
        repeat (bt / 2) @(posedge i_clk);
        `CHK("start", 1'b0, o_tx)
        for (int i = 0; i < nb; i++) begin
            repeat (bt) @(posedge i_clk);
            fr[i] = o_tx;
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Hang guard, about five times the tests' length
    initial begin
        repeat (8000) @(posedge i_clk);
        fails++;
        final_report();
    end
    // ==========================================
    // Tests
    initial begin
        i_rst = 1'b1;
        {i_wr, i_rd, i_addr, i_wdata} = '0;
        i_pin_direction = 1'b1;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        `CHK("tx_idle", 1'b1, o_tx)
        rdc("stat_reset", async_serial_pkg::OFS_STAT, 16'hFFFF, 16'h0002);
        rdc("unmapped", 4'hF, 16'hFFFF, 16'h0000);
        acc(1'b1, async_serial_pkg::OFS_BAUD, 16'h0000);
        // Each mode at 16x, then 8-bit at 4x
        for (int j = 0; j < 5; j++) begin
            acc(1'b1, async_serial_pkg::OFS_CTRL, 16'h0027 | 16'((j % 4) << 7) | (j == 4 ? 16'h0008 : 16'h0));
            rdc("stat_on", async_serial_pkg::OFS_STAT, 16'hFFFF, 16'h0023);
            acc(1'b1, async_serial_pkg::OFS_TXB, 16'h0045);
            cap(j == 4 ? 4 : 16, j % 4 == 1 ? 8 : j % 4 > 1 ? 10 : 9, 40);
            `CHK("frame", j % 4 == 1 ? 11'h7C5 : {2'b11, j % 4 == 3 ? 1'b1 : j % 4 == 0, 8'h45}, fr)
            repeat (16) @(posedge i_clk);
        end
        acc(1'b1, async_serial_pkg::OFS_CTRL, 16'h0227);
        acc(1'b1, async_serial_pkg::OFS_TXB, 16'h0045);
        repeat (40) @(posedge i_clk);
        `CHK("bad_mode", 1'b1, o_tx_oe_n)
        acc(1'b1, async_serial_pkg::OFS_CTRL, 16'h0027);
        acc(1'b1, async_serial_pkg::OFS_TXB, 16'h00A5);
        acc(1'b1, async_serial_pkg::OFS_TXB, 16'h003C);
        rdc("stat_busy", async_serial_pkg::OFS_STAT, 16'hFFFF, 16'h0000);
        cap(16, 9, 40);
        `CHK("first", 11'h7A5, fr)
        cap(16, 9, 12);
        `CHK("second", 11'h73C, fr)
        i_pin_direction <= 1'b0;
        repeat (24) @(posedge i_clk);
        `CHK("pin_dir", 1'b0, o_tx_oe_n)
        i_pin_direction <= 1'b1;
        rdc("stat_idle", async_serial_pkg::OFS_STAT, 16'hFFFF, 16'h0023);
        $display("test transmit done");
        acc(1'b1, async_serial_pkg::OFS_TXB, 16'h0000);
        repeat (20) @(posedge i_clk);
        acc(1'b1, async_serial_pkg::OFS_CTRL, 16'h0010);
        repeat (2) @(posedge i_clk);
        `CHK("abort_pol", 2'b01, {o_tx, o_tx_oe_n})
        acc(1'b1, async_serial_pkg::OFS_CTRL, 16'h0027);
        serial_station_i.send(8'h3C, 1'b0);
        serial_station_i.send(8'h55, 1'b1);
        repeat (4) @(posedge i_clk);
        rdc("stat_rx", async_serial_pkg::OFS_STAT, 16'h001F, 16'h0007);
        rdc("rx_first", async_serial_pkg::OFS_RXB, 16'h00FF, 16'h003C);
        rdc("stat_ferr", async_serial_pkg::OFS_STAT, 16'h001F, 16'h000F);
        rdc("rx_second", async_serial_pkg::OFS_RXB, 16'h00FF, 16'h0055);
        @(posedge i_clk);
        `CHK("rx_drained", 1'b0, o_rx_data_flag)
        $display("test receive done");
        final_report();
    end
endmodule // testbench
